// [hw/spp_pkg.sv]
// serial peripheral port: register offsets, field positions, reset values, states
// assumes 16-bit register accesses addressed by word offset
package spp_pkg;
    // ************************************************************
    // register offsets (word addresses)
    // ************************************************************
    localparam logic [15:0] A_CFG = 16'h7040;
    localparam logic [15:0] A_CTL = 16'h7041;
    localparam logic [15:0] A_STS = 16'h7042;
    localparam logic [15:0] A_BRR = 16'h7044;
    localparam logic [15:0] A_RXD = 16'h7046;
    localparam logic [15:0] A_RXB = 16'h7047;
    localparam logic [15:0] A_TXB = 16'h7048;
    localparam logic [15:0] A_DAT = 16'h7049;
    localparam logic [15:0] A_FTX = 16'h704a;
    localparam logic [15:0] A_FRX = 16'h704b;
    localparam logic [15:0] A_FCT = 16'h704c;
    localparam logic [15:0] A_PRI = 16'h704f;
    // ************************************************************
    // field positions
    // ************************************************************
    localparam int CFG_POL  = 6;
    localparam int CTL_RXIE = 0;
    localparam int CTL_TALK = 1;
    localparam int CTL_MST  = 2;
    localparam int CTL_PHA  = 3;
    localparam int CTL_OVIE = 4;
    localparam int CTL_TXIE = 5;
    localparam int STS_OV   = 7;
    // ************************************************************
    // reset values and divisor limits
    // ************************************************************
    localparam logic [7:0] CFG_RST   = 8'h0f;
    localparam logic [7:0] CTL_RST   = 8'h00;
    localparam logic [6:0] BRR_RST   = 7'h00;
    localparam logic [7:0] DLY_RST   = 8'h00;
    localparam logic [7:0] PRI_RST   = 8'h00;
    localparam logic [3:0] PIN_RST   = 4'h1;
    localparam logic [6:0] DIV_FLOOR = 7'h03;
    localparam logic [7:0] DIV_SLOW  = 8'h04;

    typedef enum logic [2:0] {
        SPP_IDLE = 3'b001,
        SPP_RUN  = 3'b010,
        SPP_GAP  = 3'b100
    } spp_state_t;
endpackage : spp_pkg

// [hw/spp_port.sv]
// serial peripheral port: word fifo and the port itself
// assumes pins arrive unsynchronised; registers reached by word offset, 16-bit only
`timescale 1ns/1ns

// ************************************************************
// word fifo
// ************************************************************
module spp_fifo #(
    parameter int W  = 16,
    parameter int D  = 16,
    parameter int AW = $clog2(D)
) (
    input  wire logic          ref_clk,
    input  wire logic          nrst,
    input  wire logic          in_valid,
    output logic               in_ready,
    input  wire logic [W-1:0]  in_data,
    output logic               out_valid,
    input  wire logic          out_ready,
    output logic [W-1:0]       out_data,
    output logic [AW:0]        level
);
    logic [W-1:0]  mem_ff [D];
    logic [AW-1:0] wp_ff;
    logic [AW-1:0] rp_ff;
    logic [AW:0]   cnt_ff;
    wire push = in_valid & in_ready;
    wire pop  = out_valid & out_ready;

    assign in_ready  = cnt_ff != (AW+1)'(D);
    assign out_valid = cnt_ff != '0;
    assign out_data  = mem_ff[rp_ff];
    assign level     = cnt_ff;

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_ff[wp_ff] <= in_data;
        end
    end

    // depth is a power of two, pointers wrap freely
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            wp_ff  <= '0;
            rp_ff  <= '0;
            cnt_ff <= '0;
        end else begin
            wp_ff  <= push ? wp_ff + 1'b1 : wp_ff;
            rp_ff  <= pop ? rp_ff + 1'b1 : rp_ff;
            cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : spp_fifo

module spp_port #(
    parameter int FIFO_DEPTH = 16
) (
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    input  wire logic [15:0] reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [15:0] reg_wdata,
    output logic [15:0]      reg_rdata,
    input  wire logic        serial_clock_pin_i,
    output logic             serial_clock_pin_o,
    output logic             serial_clock_pin_oe_n,
    input  wire logic        slave_in_master_out_i,
    output logic             slave_in_master_out_o,
    output logic             slave_in_master_out_oe_n,
    input  wire logic        slave_out_master_in_i,
    output logic             slave_out_master_in_o,
    output logic             slave_out_master_in_oe_n,
    input  wire logic        slave_transmit_enable_n_i,
    output logic             slave_transmit_enable_n_o,
    output logic             slave_transmit_enable_n_oe_n,
    output logic             rx_irq,
    output logic             tx_irq
);
    localparam int LW = $clog2(FIFO_DEPTH) + 1;

    logic [7:0]  cfg_ff;
    logic [7:0]  ctl_ff;
    logic [6:0]  brr_ff;
    logic [7:0]  dly_ff;
    logic [7:0]  pri_ff;
    logic        ov_ff;
    logic [15:0] rdata_ff;
    logic [15:0] dat_ff;
    logic [3:0]  s1_ff;
    logic [3:0]  s2_ff;
    logic [3:0]  s3_ff;
    logic [3:0]  flt_ff;
    logic        sclk_prev_ff;
    spp_pkg::spp_state_t st_ff;
    spp_pkg::spp_state_t nxt_st;
    logic [7:0]  hcnt_ff;
    logic [7:0]  gcnt_ff;
    logic [4:0]  ecnt_ff;
    logic [3:0]  bcnt_ff;
    logic        sclk_o_ff;
    logic        ste_o_ff;
    logic [15:0] sh_ff;
    logic [15:0] rxsh_ff;
    logic        skip_ff;
    logic [3:0]  msamp_ff;
    logic        txf_in_ready;
    logic        txf_valid;
    logic [15:0] txf_data;
    logic [LW-1:0] txf_lvl;
    logic        rxf_in_ready;
    logic        rxf_valid;
    logic [15:0] rxf_data;
    logic [LW-1:0] rxf_lvl;

    // ************************************************************
    // register decode
    // ************************************************************
    wire hit_cfg = reg_addr == spp_pkg::A_CFG;
    wire hit_ctl = reg_addr == spp_pkg::A_CTL;
    wire hit_sts = reg_addr == spp_pkg::A_STS;
    wire hit_brr = reg_addr == spp_pkg::A_BRR;
    wire hit_rxd = reg_addr == spp_pkg::A_RXD;
    wire hit_rxb = reg_addr == spp_pkg::A_RXB;
    wire hit_txb = reg_addr == spp_pkg::A_TXB;
    wire hit_dat = reg_addr == spp_pkg::A_DAT;
    wire hit_ftx = reg_addr == spp_pkg::A_FTX;
    wire hit_frx = reg_addr == spp_pkg::A_FRX;
    wire hit_fct = reg_addr == spp_pkg::A_FCT;
    wire hit_pri = reg_addr == spp_pkg::A_PRI;
    wire hit_byte = hit_cfg | hit_ctl | hit_sts | hit_brr | hit_ftx | hit_frx
                  | hit_fct | hit_pri;

    // ************************************************************
    // mode and timing
    // ************************************************************
    wire        mst        = ctl_ff[spp_pkg::CTL_MST];
    wire        talk       = ctl_ff[spp_pkg::CTL_TALK];
    wire        samp_first = ~(cfg_ff[spp_pkg::CFG_POL] ^ ctl_ff[spp_pkg::CTL_PHA]);
    wire [3:0]  lenf       = cfg_ff[3:0];
    wire [15:0] len_mask   = 16'hffff >> (4'hf - lenf);
    wire [7:0]  per     = (brr_ff < spp_pkg::DIV_FLOOR) ? spp_pkg::DIV_SLOW
                                                        : {1'b0, brr_ff} + 8'h01;
    wire [7:0]  half_lo = per >> 1;
    wire [7:0]  half_hi = per - half_lo;
    wire [7:0]  half_n  = ecnt_ff[0] ? half_lo : half_hi;
    wire        in_run  = st_ff == spp_pkg::SPP_RUN;
    wire        m_tick  = mst & in_run & (hcnt_ff == half_n - 8'h01);
    wire        gap_tick = (st_ff == spp_pkg::SPP_GAP) & (hcnt_ff == per - 8'h01);

    // ************************************************************
    // pin synchroniser, filtered when stages two and three agree
    // ************************************************************
    wire [3:0] pin_raw = {serial_clock_pin_i, slave_in_master_out_i,
                          slave_out_master_in_i, slave_transmit_enable_n_i};
    wire [3:0] agree   = ~(s2_ff ^ s3_ff);

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            s1_ff  <= spp_pkg::PIN_RST;
            s2_ff  <= spp_pkg::PIN_RST;
            s3_ff  <= spp_pkg::PIN_RST;
            flt_ff <= spp_pkg::PIN_RST;
        end else begin
            s1_ff  <= pin_raw;
            s2_ff  <= s1_ff;
            s3_ff  <= s2_ff;
            flt_ff <= (s2_ff & agree) | (flt_ff & ~agree);
        end
    end

    wire s_sclk = flt_ff[3];
    wire sel    = ~flt_ff[0];

    // ************************************************************
    // edge events shared by master and slave
    // ************************************************************
    // slave takes edges from the pin, master from its divider
    wire s_edge     = ~mst & in_run & (s_sclk != sclk_prev_ff);
    wire edge_ev    = m_tick | s_edge;
    wire first_edge = mst ? ~ecnt_ff[0] : s_sclk;
    // sample or drive edge by mode
    wire samp_ev    = edge_ev & (first_edge == samp_first);
    wire drv_ev     = edge_ev & (first_edge != samp_first);
    // receive runs whatever the transmit setting
    wire din        = mst ? flt_ff[1] : flt_ff[2];
    // master reads its data pin four cycles late: synchroniser delay
    wire samp_take  = mst ? msamp_ff[3] : samp_ev;
    wire last_bit   = bcnt_ff == lenf;
    wire rx_push    = samp_take & last_bit;
    wire [15:0] rx_word = {rxsh_ff[14:0], din} & len_mask;
    wire m_end      = m_tick & (ecnt_ff == {lenf, 1'b1});
    // master waits when receive fifo is full: back-pressure
    // no start while late samples of the word before are pending
    wire m_start    = mst & (st_ff == spp_pkg::SPP_IDLE) & txf_valid & rxf_in_ready
                    & ~(|msamp_ff);
    wire s_start    = ~mst & (st_ff == spp_pkg::SPP_IDLE) & sel;
    wire s_reload   = ~mst & rx_push & sel;
    wire load       = m_start | s_start | s_reload;
    wire [15:0] tx_word = txf_valid ? (txf_data << (4'hf - lenf)) : 16'h0000;
    wire msb_bit    = txf_data[lenf];

    // ************************************************************
    // transfer sequencer
    // ************************************************************
    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            spp_pkg::SPP_IDLE: begin
                if (m_start | s_start) begin
                    nxt_st = spp_pkg::SPP_RUN;
                end
            end
            spp_pkg::SPP_RUN: begin
                // gap only when a delay is programmed
                if (mst & m_end) begin
                    nxt_st = (dly_ff == 8'h00) ? spp_pkg::SPP_IDLE : spp_pkg::SPP_GAP;
                end else if (~mst & ~sel) begin
                    nxt_st = spp_pkg::SPP_IDLE;
                end
            end
            spp_pkg::SPP_GAP: begin
                if (gap_tick & (gcnt_ff == 8'h01)) begin
                    nxt_st = spp_pkg::SPP_IDLE;
                end
            end
            default: nxt_st = spp_pkg::SPP_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            st_ff        <= spp_pkg::SPP_IDLE;
            sclk_prev_ff <= 1'b0;
            hcnt_ff      <= 8'h00;
            gcnt_ff      <= 8'h00;
        end else begin
            st_ff        <= nxt_st;
            sclk_prev_ff <= s_sclk;
            hcnt_ff      <= (m_tick | gap_tick | ~(mst & in_run) & ~gap_tick
                             & (st_ff != spp_pkg::SPP_GAP)) ? 8'h00 : hcnt_ff + 8'h01;
            // pause counted in whole serial periods
            gcnt_ff      <= m_end ? dly_ff : (gap_tick ? gcnt_ff - 8'h01 : gcnt_ff);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            ecnt_ff   <= 5'h00;
            bcnt_ff   <= 4'h0;
            sclk_o_ff <= 1'b0;
            ste_o_ff  <= 1'b1;
            msamp_ff  <= 4'h0;
        end else begin
            ecnt_ff   <= load ? 5'h00 : (m_tick ? ecnt_ff + 5'h01 : ecnt_ff);
            bcnt_ff   <= (load | rx_push) ? 4'h0 : (samp_take ? bcnt_ff + 4'h1 : bcnt_ff);
            msamp_ff  <= {msamp_ff[2:0], mst & samp_ev};
            // clock toggles only from the master divider
            sclk_o_ff <= (mst & in_run) ? (sclk_o_ff ^ m_tick) : 1'b0;
            // select held low for each master word
            ste_o_ff  <= ~(mst & (nxt_st == spp_pkg::SPP_RUN));
        end
    end

    // skip drops a drive edge the load already covers: after a slave reload, or the first edge when drive comes first
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            sh_ff   <= 16'h0000;
            rxsh_ff <= 16'h0000;
            skip_ff <= 1'b0;
            dat_ff  <= 16'h0000;
        end else begin
            if (load) begin
                sh_ff <= tx_word;
            end else if (drv_ev & ~skip_ff) begin
                sh_ff <= {sh_ff[14:0], 1'b0};
            end
            skip_ff <= load ? (s_reload | ~samp_first) : (skip_ff & ~drv_ev);
            rxsh_ff <= samp_take ? {rxsh_ff[14:0], din} : rxsh_ff;
            dat_ff  <= rx_push ? rx_word : dat_ff;
        end
    end

    // ************************************************************
    // fifos
    // ************************************************************
    spp_fifo #(.W(16), .D(FIFO_DEPTH)) u_txf (
        .ref_clk   (ref_clk),
        .nrst      (nrst),
        .in_valid  (reg_wr & (hit_txb | hit_dat)),
        .in_ready  (txf_in_ready),
        .in_data   (reg_wdata),
        .out_valid (txf_valid),
        .out_ready (load),
        .out_data  (txf_data),
        .level     (txf_lvl)
    );

    spp_fifo #(.W(16), .D(FIFO_DEPTH)) u_rxf (
        .ref_clk   (ref_clk),
        .nrst      (nrst),
        .in_valid  (rx_push),
        .in_ready  (rxf_in_ready),
        .in_data   (rx_word),
        .out_valid (rxf_valid),
        .out_ready (reg_rd & hit_rxb),
        .out_data  (rxf_data),
        .level     (rxf_lvl)
    );

    // ************************************************************
    // registers
    // ************************************************************
    // overrun sticky; a new overrun beats the clear
    wire ov_clr = reg_wr & hit_sts & reg_wdata[spp_pkg::STS_OV];
    wire ov_set = rx_push & ~rxf_in_ready;

    // control registers keep the low byte only, the divisor its low seven bits
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            cfg_ff <= spp_pkg::CFG_RST;
            ctl_ff <= spp_pkg::CTL_RST;
            brr_ff <= spp_pkg::BRR_RST;
            dly_ff <= spp_pkg::DLY_RST;
            pri_ff <= spp_pkg::PRI_RST;
            ov_ff  <= 1'b0;
        end else begin
            cfg_ff <= (reg_wr & hit_cfg) ? reg_wdata[7:0] : cfg_ff;
            ctl_ff <= (reg_wr & hit_ctl) ? reg_wdata[7:0] : ctl_ff;
            brr_ff <= (reg_wr & hit_brr) ? reg_wdata[6:0] : brr_ff;
            dly_ff <= (reg_wr & hit_fct) ? reg_wdata[7:0] : dly_ff;
            pri_ff <= (reg_wr & hit_pri) ? reg_wdata[7:0] : pri_ff;
            ov_ff  <= ov_set | (ov_ff & ~ov_clr);
        end
    end

    wire [7:0] sts_rd = {ov_ff, rxf_valid, ~txf_in_ready, 5'h00};
    wire [7:0] ftx_rd = {2'b00, ~txf_valid, 5'(txf_lvl)};
    wire [7:0] frx_rd = {2'b00, ~rxf_in_ready, 5'(rxf_lvl)};
    wire [7:0] byte_rd = hit_cfg ? cfg_ff
                       : hit_ctl ? ctl_ff
                       : hit_sts ? sts_rd
                       : hit_brr ? {1'b0, brr_ff}
                       : hit_ftx ? ftx_rd
                       : hit_frx ? frx_rd
                       : hit_fct ? dly_ff
                       : hit_pri ? pri_ff : 8'h00;
    // upper byte of control reads is zero
    wire [15:0] rmux = hit_byte ? {8'h00, byte_rd}
                     : (hit_rxd | hit_rxb) ? rxf_data
                     : hit_dat ? dat_ff : 16'h0000;

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            rdata_ff <= 16'h0000;
        end else begin
            rdata_ff <= reg_rd ? rmux : rdata_ff;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign reg_rdata                    = rdata_ff;
    assign serial_clock_pin_o           = sclk_o_ff;
    assign serial_clock_pin_oe_n        = ~mst;
    assign slave_transmit_enable_n_o    = ste_o_ff;
    assign slave_transmit_enable_n_oe_n = ~mst;
    assign slave_in_master_out_o        = sh_ff[15];
    assign slave_out_master_in_o        = sh_ff[15];
    // transmit disable only releases the data line
    assign slave_in_master_out_oe_n     = ~(mst & talk);
    assign slave_out_master_in_oe_n     = ~(~mst & talk & sel);
    // request lines for polled or interrupt service
    assign rx_irq = (ctl_ff[spp_pkg::CTL_RXIE] & rxf_valid) | (ctl_ff[spp_pkg::CTL_OVIE] & ov_ff);
    assign tx_irq = ctl_ff[spp_pkg::CTL_TXIE] & ~txf_valid;

    // ************************************************************
    // checks
    // ************************************************************
    logic [7:0] per_cnt_ff;
    logic       per_ok_ff;
    wire        m_rise = m_tick & ~sclk_o_ff;

    always_ff @(posedge ref_clk) begin
        if (!nrst | ~(mst & in_run)) begin
            per_cnt_ff <= 8'h00;
            per_ok_ff  <= 1'b0;
        end else begin
            per_cnt_ff <= m_rise ? 8'h01 : per_cnt_ff + 8'h01;
            per_ok_ff  <= per_ok_ff | m_rise;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    a_word_length: assert property (
        rx_push |-> (rx_word & ~len_mask) == 16'h0000)
        else $error("received bits above word length");
    a_master_drive: assert property (
        mst |-> !serial_clock_pin_oe_n && !slave_transmit_enable_n_oe_n)
        else $error("master not driving clock and select");
    a_div_period: assert property (
        (m_rise && per_ok_ff && brr_ff >= 7'h03) |-> per_cnt_ff == {1'b0, brr_ff} + 8'h01)
        else $error("serial period differs from divisor plus one");
    a_div_slow: assert property (
        (m_rise && per_ok_ff && brr_ff < 7'h03) |-> per_cnt_ff == 8'h04)
        else $error("low divisor period is not four");
    // data changes only on the drive edge
    a_drive_edge: assert property (
        (mst && in_run && $past(in_run) && $changed(sh_ff[15]))
        |-> ($changed(sclk_o_ff) && sclk_o_ff == ~samp_first))
        else $error("master data changed off the drive edge");
    a_talk_off: assert property (
        !talk |-> slave_in_master_out_oe_n && slave_out_master_in_oe_n)
        else $error("data line driven with transmit disabled");
    a_ov_sticky: assert property (
        ov_set |=> ov_ff [*2])
        else $error("overrun flag lost");
    a_ste_frame: assert property (
        (mst && in_run) |-> !slave_transmit_enable_n_o)
        else $error("select high during master word");
    a_upper_zero: assert property (
        (reg_rd && hit_byte) |=> reg_rdata[15:8] == 8'h00)
        else $error("upper byte of control read not zero");
    a_gap_hold: assert property (
        (m_end && dly_ff != 8'h00) |=> !in_run [*2])
        else $error("next word started inside the gap");
    a_msb_first: assert property (
        m_start |=> sh_ff[15] == $past(msb_bit))
        else $error("first bit is not the word msb");

    c_master_word: cover property (m_end);
    c_slave_word:  cover property (~mst && rx_push);
    c_overrun:     cover property (ov_set);
endmodule : spp_port

// [bench/spp_slave_model.sv]
// far-side slave for the serial port, mode 0, 8-bit words
// assumes the port is master and drives clock and select
`timescale 1ns/1ns
module spp_slave_model (
    input  wire logic       sclk,
    input  wire logic       sel_n,
    input  wire logic       mosi,
    input  wire logic [7:0] load,
    output logic            miso,
    output logic [7:0]      got
);
    logic [7:0] sh;
    logic       last;
    initial begin
        sh = 8'h00;
        got = 8'h00;
        last = 1'b0;
    end
    always @(negedge sel_n) sh = load;
    always @(posedge sel_n) last = sh[7];
    always @(posedge sclk) if (!sel_n) got = {got[6:0], mosi};
    always @(negedge sclk) if (!sel_n) sh = {sh[6:0], 1'b0};
    // released line shows the inverse, never a stale bit
    assign miso = sel_n ? ~last : sh[7];
endmodule : spp_slave_model

// [bench/serial_peripheral_port_tb.sv]
// testbench for the serial port: register access, transfers, fifo
// assumes the slave model on the far side of the pins
`timescale 1ns/1ns
module serial_peripheral_port_tb;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] reg_rdata;
    logic sck, sck_oe_n, mo, mo_oe_n, mi, si_o, si_oe_n, sel, sel_oe_n;
    logic [7:0] load = 8'h3c;
    logic [7:0] got;
    logic rxi, txi;
    int num_errors = 0;
    int total_checks = 0;
    always #25 ref_clk = ~ref_clk;
    spp_port i_dut (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .serial_clock_pin_i(sck), .serial_clock_pin_o(sck),
        .serial_clock_pin_oe_n(sck_oe_n), .slave_in_master_out_i(mo),
        .slave_in_master_out_o(mo), .slave_in_master_out_oe_n(mo_oe_n),
        .slave_out_master_in_i(mi), .slave_out_master_in_o(si_o),
        .slave_out_master_in_oe_n(si_oe_n), .slave_transmit_enable_n_i(sel),
        .slave_transmit_enable_n_o(sel), .slave_transmit_enable_n_oe_n(sel_oe_n),
        .rx_irq(rxi), .tx_irq(txi));
    spp_slave_model i_slv (.sclk(sck), .sel_n(sel), .mosi(mo), .load(load),
        .miso(mi), .got(got));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(negedge ref_clk);
        {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        @(negedge ref_clk);
        reg_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(negedge ref_clk);
        {reg_rd, reg_addr} = {1'b1, a};
        @(negedge ref_clk);
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask : rd
    task automatic wait_rx();
        logic [15:0] v;
        v = 16'h0000;
        for (int i = 0; i < 3000 && v[6] !== 1'b1; i++) rd(spp_pkg::A_STS, v);
    endtask : wait_rx
    task automatic t_regs();
        logic [15:0] v;
        rd(spp_pkg::A_CFG, v); chk(v, 16'h000f);
        rd(spp_pkg::A_CTL, v); chk(v, 16'h0000);
        rd(16'h7043, v); chk(v, 16'h0000);
        wr(spp_pkg::A_CFG, 16'h1207);
        rd(spp_pkg::A_CFG, v); chk(v, 16'h0007);
        wr(spp_pkg::A_CTL, 16'h0021);
        chk({15'h0, txi}, 16'h0001);
        chk({15'h0, rxi}, 16'h0000);
        wr(spp_pkg::A_CTL, 16'h0000);
    endtask : t_regs
    // period in ref cycles, select low, received and sent words
    task automatic t_xfer(input logic [15:0] brr, input logic [15:0] ctl,
                          input logic [15:0] per);
        logic [15:0] v;
        time t0;
        wr(spp_pkg::A_BRR, brr);
        wr(spp_pkg::A_CTL, ctl);
        wr(spp_pkg::A_TXB, 16'h00a5);
        @(posedge sck);
        t0 = $time;
        @(posedge sck);
        chk(16'(($time - t0) / 50), per);
        chk({15'h0, sel}, 16'h0000);
        chk({15'h0, mo_oe_n}, {15'h0, ~ctl[1]});
        wait_rx();
        rd(spp_pkg::A_RXD, v); chk(v, 16'h003c);
        rd(spp_pkg::A_DAT, v); chk(v, 16'h003c);
        rd(spp_pkg::A_RXB, v); chk(v, 16'h003c);
        if (ctl[1]) chk({8'h00, got}, 16'h00a5);
    endtask : t_xfer
    task automatic t_fifo();
        logic [15:0] v;
        wr(spp_pkg::A_CTL, 16'h0002);
        for (int i = 0; i < 17; i++) wr(spp_pkg::A_TXB, 16'(i));
        rd(spp_pkg::A_FTX, v); chk(v, 16'h0010);
        rd(spp_pkg::A_STS, v); chk(v & 16'h0020, 16'h0020);
        wr(spp_pkg::A_CTL, 16'h0006);
        v = 16'h0000;
        for (int i = 0; i < 3000 && v[5] !== 1'b1; i++) rd(spp_pkg::A_FTX, v);
        repeat (60) @(negedge ref_clk);
        rd(spp_pkg::A_FRX, v); chk(v, 16'h0030);
        for (int i = 0; i < 16; i++) begin
            rd(spp_pkg::A_RXB, v); chk(v, 16'h003c);
        end
        rd(spp_pkg::A_STS, v); chk(v & 16'h0040, 16'h0000);
    endtask : t_fifo
    task automatic conclude();
        $display("errors %0d checks %0d", num_errors, total_checks);
        if (num_errors == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : conclude
    initial begin
        #2000000;
        num_errors++;
        conclude();
    end
    initial begin
        repeat (20) @(negedge ref_clk);
        nrst = 1'b1;
        t_regs();
        // master, divisor floor then odd divisor
        t_xfer(16'h0000, 16'h0006, 16'd4);
        t_xfer(16'h0009, 16'h0004, 16'd10);
        wr(spp_pkg::A_BRR, 16'h0000);
        t_fifo();
        conclude();
    end
endmodule : serial_peripheral_port_tb
